// ==== src/virq_ctrl.sv ====
// interrupt controller top: non-maskable pin gating, maskable lines, vector and registers
// Operation
// - synchronise pin, trigger on falling edge only
// - ignored after reset; lock keeps enabled
// - plain enable lasts until request, reset or a write of zero
// - hardware clears enable at reset, on record
// - enable set only while pending clear
// - lock set overrides the plain enable
// - lock cleared only by reset
// - control bit 1 reads pin level, read-only
// - test, enable, lock cleared on reset
// - pending bit 0; cleared by reset, read
// - 47 level lines, higher number wins
// - vector is line plus 10h, top zero
// - acknowledge reads stable vector at fffe00
// - no enabled request gives vector 10h
// - low mask gates 1-15, bit0 ignored, ffff
// - mid mask gates 16-31, resets ffff
// - raw status shows line levels, unmasked, read-only
// - low raw status bit 0 reads zero
// - mid raw status maps lines 31-16
// - high mask and raw status for 32-47
`timescale 1ns/100ps
`default_nettype none
module virq_ctrl #(
  parameter int unsigned NUM_LINES = 47
) (
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_n_in,
  // active-low non-maskable pin, asynchronous
  input  wire logic                         nonmask_pin_n_in,
  // maskable request lines 1..NUM_LINES, same clock, level sensitive
  input  wire logic [NUM_LINES:1]           irq_line_in,
  // register port of the core bus
  input  wire logic [virq_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic                         reg_rd_in,
  input  wire logic                         reg_wr_in,
  input  wire logic [virq_pkg::DATA_W-1:0]  reg_wdata_in,
  output logic      [virq_pkg::DATA_W-1:0]  reg_rdata_out,
  output logic                              reg_rvalid_out,
  // requests toward the processor
  output logic                              irq_req_out,
  output logic                              nmi_req_out
);

  localparam int unsigned LINES = NUM_LINES + 1;
  localparam int unsigned IDX_W = $clog2(LINES);
  localparam int unsigned MASK_W = 3 * virq_pkg::DATA_W;

  typedef struct packed {
    logic [virq_pkg::DATA_W-1:0] mask_low;
    logic [virq_pkg::DATA_W-1:0] mask_mid;
    logic [virq_pkg::DATA_W-1:0] mask_high;
    logic                        line_en;
    logic                        lock_en;
    logic                        test_bit;
    logic                        ext_flag;
    logic                        pin_prev;
    logic [7:0]                  vector;
    logic                        irq_req;
    logic [virq_pkg::DATA_W-1:0] rdata;
    logic                        rvalid;
  } virq_state_t;

  virq_state_t st_reg;
  virq_state_t st_next;

  logic             pin_level;
  logic [LINES-1:0] raw_lines;
  logic [LINES-1:0] live_lines;
  logic [MASK_W-1:0] mask_all;
  logic [IDX_W-1:0] top_index;
  logic             top_any;
  logic             pin_fall;
  logic             nmi_enabled;
  logic             nmi_event;

  function automatic logic addr_hit(input logic [virq_pkg::ADDR_W-1:0] a,
                                    input logic [virq_pkg::ADDR_W-1:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  virq_pin_sync u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (nonmask_pin_n_in),
    .level_out  (pin_level)
  );

  // line 0 has no source and is tied low
  assign raw_lines = {irq_line_in, 1'b0};
  assign mask_all  = {st_reg.mask_high, st_reg.mask_mid, st_reg.mask_low};

  // mask bit 0 is harmless since line 0 never asserts
  assign live_lines = raw_lines & mask_all[LINES-1:0];

  virq_prio_enc #(
    .LINES (LINES)
  ) u_prio_enc (
    .req_in    (live_lines),
    .index_out (top_index),
    .any_out   (top_any)
  );

  // falling edge of the filtered pin level
  assign pin_fall    = st_reg.pin_prev & ~pin_level;
  // lock overrides the plain enable; both clear after reset
  assign nmi_enabled = st_reg.lock_en | st_reg.line_en;
  assign nmi_event   = pin_fall & nmi_enabled;

  // raw status word for a 16-bit slice starting at line lo
  function automatic logic [virq_pkg::DATA_W-1:0] raw_slice(input logic [LINES-1:0] lines,
                                                             input int unsigned lo);
    logic [MASK_W-1:0] wide;
    wide      = '0;
    wide[LINES-1:0] = lines;
    raw_slice = wide[lo +: virq_pkg::DATA_W];
  endfunction

  always_comb begin
    st_next          = st_reg;
    st_next.pin_prev = pin_level;
    st_next.rvalid   = reg_rd_in;
    st_next.rdata    = '0;

    // vector follows the lines every cycle; a read sees the registered copy
    st_next.vector  = virq_pkg::VECTOR_BASE + {{(8 - IDX_W){1'b0}}, top_index};
    st_next.irq_req = top_any;

    // register writes; 16-bit words, byte registers use the low lane
    if (reg_wr_in) begin
      if (addr_hit(reg_addr_in, virq_pkg::PIN_CONTROL_ADDR)) begin
        // setting takes effect only while nothing is pending; clearing always works
        if (reg_wdata_in[virq_pkg::CTRL_EN_BIT]) begin
          if (!st_reg.ext_flag) begin
            st_next.line_en = 1'b1;
          end
        end else begin
          st_next.line_en = 1'b0;
        end
        // lock can only be set by software
        if (reg_wdata_in[virq_pkg::CTRL_LOCK_BIT]) begin
          st_next.lock_en = 1'b1;
        end
        st_next.test_bit = reg_wdata_in[virq_pkg::CTRL_TEST_BIT];
      end else if (addr_hit(reg_addr_in, virq_pkg::MASK_LOW_ADDR)) begin
        st_next.mask_low = reg_wdata_in;
      end else if (addr_hit(reg_addr_in, virq_pkg::MASK_MID_ADDR)) begin
        st_next.mask_mid = reg_wdata_in;
      end else if (addr_hit(reg_addr_in, virq_pkg::MASK_HIGH_ADDR)) begin
        st_next.mask_high = reg_wdata_in;
      end
      // raw status, vector and pending are read-only; writes fall through
    end

    // register reads
    if (reg_rd_in) begin
      if (addr_hit(reg_addr_in, virq_pkg::VECTOR_CODE_ADDR)) begin
        // upper two bits of the byte are always zero by the encoding
        st_next.rdata = {8'h00, st_reg.vector};
      end else if (addr_hit(reg_addr_in, virq_pkg::NONMASK_PENDING_ADDR)) begin
        st_next.rdata[virq_pkg::PEND_EXT_BIT] = st_reg.ext_flag;
        st_next.ext_flag = 1'b0;
      end else if (addr_hit(reg_addr_in, virq_pkg::PIN_CONTROL_ADDR)) begin
        st_next.rdata[virq_pkg::CTRL_EN_BIT]   = st_reg.line_en;
        st_next.rdata[virq_pkg::CTRL_PIN_BIT]  = pin_level;
        st_next.rdata[virq_pkg::CTRL_LOCK_BIT] = st_reg.lock_en;
        st_next.rdata[virq_pkg::CTRL_TEST_BIT] = st_reg.test_bit;
      end else if (addr_hit(reg_addr_in, virq_pkg::RAW_STATUS_LOW_ADDR)) begin
        // line 0 is tied low, so bit 0 reads zero
        st_next.rdata = raw_slice(raw_lines, 0);
      end else if (addr_hit(reg_addr_in, virq_pkg::RAW_STATUS_MID_ADDR)) begin
        st_next.rdata = raw_slice(raw_lines, 16);
      end else if (addr_hit(reg_addr_in, virq_pkg::RAW_STATUS_HIGH_ADDR)) begin
        st_next.rdata = raw_slice(raw_lines, 32);
      end else if (addr_hit(reg_addr_in, virq_pkg::MASK_LOW_ADDR)) begin
        st_next.rdata = st_reg.mask_low;
      end else if (addr_hit(reg_addr_in, virq_pkg::MASK_MID_ADDR)) begin
        st_next.rdata = st_reg.mask_mid;
      end else if (addr_hit(reg_addr_in, virq_pkg::MASK_HIGH_ADDR)) begin
        st_next.rdata = st_reg.mask_high;
      end
    end

    // a recorded edge beats both the read clear and a software set of enable
    if (nmi_event) begin
      st_next.ext_flag = 1'b1;
      st_next.line_en  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg.mask_low  <= virq_pkg::MASK_RESET;
      st_reg.mask_mid  <= virq_pkg::MASK_RESET;
      st_reg.mask_high <= virq_pkg::MASK_RESET;
      st_reg.line_en   <= virq_pkg::CTRL_RESET;
      st_reg.lock_en   <= virq_pkg::CTRL_RESET;
      st_reg.test_bit  <= virq_pkg::CTRL_RESET;
      st_reg.ext_flag  <= 1'b0;
      st_reg.pin_prev  <= virq_pkg::PIN_IDLE;
      st_reg.vector    <= virq_pkg::VECTOR_RESET;
      st_reg.irq_req   <= 1'b0;
      st_reg.rdata     <= '0;
      st_reg.rvalid    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_out  = st_reg.rdata;
  assign reg_rvalid_out = st_reg.rvalid;
  assign irq_req_out    = st_reg.irq_req;
  // request stays up until software reads the pending register
  assign nmi_req_out    = st_reg.ext_flag;

endmodule
`default_nettype wire

// ==== src/virq_pkg.sv ====
// shared constants for the vectored interrupt and non-maskable request controller
package virq_pkg;

  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned DATA_W       = 16;

  // register byte addresses
  localparam logic [23:0] VECTOR_CODE_ADDR     = 24'hfffe00;
  localparam logic [23:0] NONMASK_PENDING_ADDR = 24'hfffe02;
  localparam logic [23:0] PIN_CONTROL_ADDR     = 24'hfffe04;
  localparam logic [23:0] RAW_STATUS_LOW_ADDR  = 24'hfffe0a;
  localparam logic [23:0] RAW_STATUS_MID_ADDR  = 24'hfffe0c;
  localparam logic [23:0] MASK_LOW_ADDR        = 24'hfffe0e;
  localparam logic [23:0] MASK_MID_ADDR        = 24'hfffe10;
  localparam logic [23:0] RAW_STATUS_HIGH_ADDR = 24'hfffe20;
  localparam logic [23:0] MASK_HIGH_ADDR       = 24'hfffe22;

  // field positions in the pin control register
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_PIN_BIT  = 1;
  localparam int unsigned CTRL_LOCK_BIT = 2;
  localparam int unsigned CTRL_TEST_BIT = 3;

  // field position in the pending register
  localparam int unsigned PEND_EXT_BIT  = 0;

  // values after reset
  localparam logic [15:0] MASK_RESET    = 16'hffff;
  localparam logic        CTRL_RESET    = 1'h0;
  localparam logic        PIN_IDLE      = 1'h1;
  localparam logic [7:0]  VECTOR_RESET  = 8'h10;

  // vector encoding: line number plus this base
  localparam logic [7:0]  VECTOR_BASE   = 8'h10;

  // synchroniser depth on the pin
  localparam int unsigned SYNC_STAGES   = 3;

endpackage

// ==== src/virq_pin_sync.sv ====
// three-stage synchroniser with agreement filter for the non-maskable pin
`timescale 1ns/100ps
`default_nettype none
module virq_pin_sync (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } virq_sync_t;

  virq_sync_t st_reg;
  virq_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a change is taken only once stages two and three agree
    if (st_reg.s2 == st_reg.s3) begin
      st_next.level = st_reg.s3;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '{s1: virq_pkg::PIN_IDLE, s2: virq_pkg::PIN_IDLE,
                  s3: virq_pkg::PIN_IDLE, level: virq_pkg::PIN_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;

endmodule
`default_nettype wire

// ==== src/virq_prio_enc.sv ====
// fixed-priority encoder: highest set line number wins, zero when none
`timescale 1ns/100ps
`default_nettype none
module virq_prio_enc #(
  parameter int unsigned LINES = 48
) (
  input  wire logic [LINES-1:0]         req_in,
  output logic      [$clog2(LINES)-1:0] index_out,
  output logic                          any_out
);

  always_comb begin
    index_out = '0;
    any_out   = 1'b0;
    // scanning upward lets the highest number overwrite the lower ones
    for (int i = 1; i < LINES; i++) begin
      if (req_in[i]) begin
        index_out = ($clog2(LINES))'(i);
        any_out   = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/virq_ctrl_sva.sv ====
// port assertions for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module virq_ctrl_sva #(
  parameter int unsigned NUM_LINES = 47
) (
  input wire logic                 ref_clk_in,
  input wire logic                 rst_n_in,
  input wire logic                 nonmask_pin_n_in,
  input wire logic [NUM_LINES:1]   irq_line_in,
  input wire logic [23:0]          reg_addr_in,
  input wire logic                 reg_rd_in,
  input wire logic                 reg_wr_in,
  input wire logic [15:0]          reg_wdata_in,
  input wire logic [15:0]          reg_rdata_out,
  input wire logic                 reg_rvalid_out,
  input wire logic                 irq_req_out,
  input wire logic                 nmi_req_out
);
  wire logic pend_rd = reg_rd_in && reg_addr_in == virq_pkg::NONMASK_PENDING_ADDR;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // vector register lags the lines by one edge, so two quiet samples are needed
  sequence s_quiet_vec_rd;
    irq_line_in == '0 ##1 irq_line_in == '0 && reg_rd_in && reg_addr_in == virq_pkg::VECTOR_CODE_ADDR;
  endsequence
  a_rd_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
  a_rvalid_pulse: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray rvalid");
  a_rdata_quiet: assert property (!reg_rvalid_out |-> reg_rdata_out == '0) else $error("rdata not idle");
  a_idle_vector: assert property (s_quiet_vec_rd |=> reg_rdata_out == 16'h0010) else $error("idle vector");
  a_nmi_holds: assert property (nmi_req_out && !pend_rd |=> nmi_req_out) else $error("nmi dropped");
  a_nmi_cause: assert property ($rose(nmi_req_out) |-> !$past(nonmask_pin_n_in, 2)) else $error("nmi cause");
  a_irq_quiet: assert property (irq_line_in == '0 |=> !irq_req_out) else $error("irq without line");
  a_irq_cause: assert property ($rose(irq_req_out) |-> $past(|irq_line_in)) else $error("irq cause");
endmodule
bind virq_ctrl virq_ctrl_sva #(.NUM_LINES(NUM_LINES)) i_virq_ctrl_sva (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .nonmask_pin_n_in(nonmask_pin_n_in),
  .irq_line_in(irq_line_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .irq_req_out(irq_req_out), .nmi_req_out(nmi_req_out));
`default_nettype wire

// ==== verification/virq_cpu_model.sv ====
// processor-side model: register reads, writes and acknowledge reads
`timescale 1ns/100ps
`default_nettype none
module virq_cpu_model (
  input  wire logic        ref_clk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output var logic  [23:0] addr_out,
  output var logic         rd_out,
  output var logic         wr_out,
  output var logic  [15:0] wdata_out
);
  initial begin
    addr_out = '0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = '0;
  end
  // callers keep reserved control bits zero; released lines show inverted values
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge ref_clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // also the acknowledge read of the vector byte; missing answer reads as garbage
  task automatic rd(input logic [23:0] a, output logic [15:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge ref_clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rvalid_in ? rdata_in : 16'hdead;
  endtask
endmodule
`default_nettype wire

// ==== verification/virq_ctrl_bench.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module virq_ctrl_bench;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        pin_n = 1'b1;
  logic [47:1] lines = '0;
  logic [23:0] addr;
  logic        rd;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        irq_req;
  logic        nmi_req;
  int          failures = 0;
  int          samples_checked = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  virq_ctrl i_virq_ctrl (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .nonmask_pin_n_in(pin_n),
    .irq_line_in(lines), .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .irq_req_out(irq_req), .nmi_req_out(nmi_req));
  virq_cpu_model i_virq_cpu_model (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [23:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_virq_cpu_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic put(input logic [23:0] a, input logic [15:0] d);
    i_virq_cpu_model.wr(a, d);
  endtask
  // low long enough to clear the filter, then high again so the next fall counts
  task automatic fall();
    pin_n = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    pin_n = 1'b1;
    repeat (8) @(negedge ref_clk_in);
  endtask
  task automatic t_resets();
    rc(virq_pkg::MASK_LOW_ADDR, 16'hffff);
    rc(virq_pkg::MASK_MID_ADDR, 16'hffff);
    rc(virq_pkg::MASK_HIGH_ADDR, 16'hffff);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0002);
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0000);
    rc(virq_pkg::VECTOR_CODE_ADDR, 16'h0010);
    $display("test resets done");
  endtask
  task automatic t_prio();
    lines[5] = 1'b1;
    lines[40] = 1'b1;
    rc(virq_pkg::VECTOR_CODE_ADDR, 16'h0038);
    chk({15'h0, irq_req}, 16'h0001);
    rc(virq_pkg::RAW_STATUS_LOW_ADDR, 16'h0020);
    put(virq_pkg::MASK_HIGH_ADDR, 16'hfeff);
    rc(virq_pkg::VECTOR_CODE_ADDR, 16'h0015);
    rc(virq_pkg::RAW_STATUS_HIGH_ADDR, 16'h0100);
    lines[16] = 1'b1;
    lines[31] = 1'b1;
    put(virq_pkg::RAW_STATUS_MID_ADDR, 16'h0000);
    rc(virq_pkg::RAW_STATUS_MID_ADDR, 16'h8001);
    rc(virq_pkg::VECTOR_CODE_ADDR, 16'h002f);
    put(virq_pkg::MASK_MID_ADDR, 16'h0000);
    put(virq_pkg::MASK_LOW_ADDR, 16'h0001);
    rc(virq_pkg::VECTOR_CODE_ADDR, 16'h0010);
    chk({15'h0, irq_req}, 16'h0000);
    put(virq_pkg::MASK_HIGH_ADDR, 16'hffff);
    lines[47] = 1'b1;
    rc(virq_pkg::VECTOR_CODE_ADDR, 16'h003f);
    lines = '0;
    put(virq_pkg::MASK_LOW_ADDR, 16'hffff);
    put(virq_pkg::MASK_MID_ADDR, 16'hffff);
    rc(virq_pkg::VECTOR_CODE_ADDR, 16'h0010);
    $display("test priority done");
  endtask
  task automatic t_nmi_off();
    pin_n = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0002);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0000);
    pin_n = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    chk({15'h0, nmi_req}, 16'h0000);
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0000);
    $display("test nmi disabled done");
  endtask
  task automatic t_nmi_en();
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0001);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0003);
    fall();
    chk({15'h0, nmi_req}, 16'h0001);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0002);
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0001);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0002);
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0001);
    // pending is clear now, so only a still-armed enable could record this fall
    fall();
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0000);
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0001);
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0000);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0002);
    $display("test nmi enable done");
  endtask
  task automatic t_lock();
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0004);
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0000);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0006);
    fall();
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0001);
    fall();
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0001);
    // split the pulse: the fall is read and cleared before the rise, which must record nothing
    pin_n = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0001);
    pin_n = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    rc(virq_pkg::NONMASK_PENDING_ADDR, 16'h0000);
    put(virq_pkg::PIN_CONTROL_ADDR, 16'h0009);
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h000f);
    rst_n_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    rc(virq_pkg::PIN_CONTROL_ADDR, 16'h0002);
    $display("test lock done");
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    t_resets();
    t_prio();
    t_nmi_off();
    t_nmi_en();
    t_lock();
    complete_run();
  end
  // the sequence needs about two hundred cycles; this cuts a hang well past that
  initial begin
    #(40 * 5000);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
